/* src/emifc_pkg.sv */
// Constants, encodings and state types for the external memory control block
package emifc_pkg;

	// ----------------------------------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;

	// Control register fields
	localparam int CTRL_DIV_LSB = 0; // Divided output clock ratio, 2 bits
	localparam int CTRL_RES_BIT = 2; // read_enable_select of the space_secondary_control
	localparam int CTRL_SDRAM_BIT = 3; // SDRAM fitted
	localparam int CTRL_GPO_BIT = 4; // Clock enable pin value when no SDRAM
	localparam int CTRL_SREF_BIT = 5; // Self-refresh request
	localparam int CTRL_BREQ_BIT = 6; // Software wants the bus while it is held
	localparam int CTRL_WIDTH = 7;
	localparam logic [6:0] CTRL_RESET = 7'h00;

	// Status register fields
	localparam int STAT_ACK_BIT = 0;
	localparam int STAT_SREF_BIT = 1;
	localparam int STAT_SRC_LSB = 2; // Clock source taken from the straps, 2 bits
	localparam int STAT_BUSY_BIT = 4;
	localparam int STAT_HREQ_BIT = 5;

	// ----------------------------------------------------------------
	// Clock sources and ratios
	// ----------------------------------------------------------------
	localparam logic [1:0] SRC_EXT = 2'h0;
	localparam logic [1:0] SRC_CPU4 = 2'h1;
	localparam logic [1:0] SRC_CPU6 = 2'h2;
	localparam logic [1:0] SRC_EXT_ALT = 2'h3;
	localparam logic [1:0] DIV_BY1 = 2'h0;
	localparam logic [1:0] DIV_BY2 = 2'h1;
	localparam logic [1:0] DIV_BY4 = 2'h2;
	localparam logic [2:0] CPU4_COUNT = 3'h4;
	localparam logic [2:0] CPU6_COUNT = 3'h6;

	// ----------------------------------------------------------------
	// Access types and timing, in ticks of the selected interface clock
	// ----------------------------------------------------------------
	localparam logic [1:0] MEM_ASYNC = 2'h0;
	localparam logic [1:0] MEM_SDRAM = 2'h1;
	localparam logic [1:0] MEM_SYNC = 2'h2;
	localparam logic [1:0] STROBE_TICKS = 2'h2;

	typedef enum logic [1:0] {
		ARB_OWN = 2'b00,
		ARB_DRAIN = 2'b01,
		ARB_FLOAT = 2'b10,
		ARB_HELD = 2'b11
	} emifc_arb_e;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_SETUP = 3'b001,
		SEQ_STROBE = 3'b010,
		SEQ_HOLD = 3'b011,
		SEQ_SREF = 3'b100
	} emifc_seq_e;

endpackage

/* src/emifc_clkgen.sv */
// Interface clock source selection and output clock generation
`timescale 1ns/1ns
module emifc_clkgen (
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic ext_if_clock_in, // External interface clock pin
	input wire logic [1:0] src, // Selected source
	input wire logic [1:0] div_sel, // Divided output ratio
	output logic ext_if_clock_out_full, // Output clock at source rate
	output logic ext_if_clock_out_div, // Output clock at divided rate
	output logic tick // One-cycle pulse on each source rising edge
);
	logic ext_meta;
	logic ext_sync;
	logic [2:0] cpu_cnt;
	logic src_level;
	logic src_prev;
	logic [1:0] div_cnt;

	// ----------------------------------------------------------------
	// Sources
	// ----------------------------------------------------------------
	// External pin is asynchronous, so two flops before any use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			ext_meta <= ext_if_clock_in;
			ext_sync <= ext_meta;
		end
	end

	// Shared counter for the CPU/4 and CPU/6 sources
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_cnt <= 3'h0;
		end else if ((src == emifc_pkg::SRC_CPU4 && cpu_cnt == emifc_pkg::CPU4_COUNT - 3'h1) ||
				(src == emifc_pkg::SRC_CPU6 && cpu_cnt == emifc_pkg::CPU6_COUNT - 3'h1)) begin
			cpu_cnt <= 3'h0;
		end else begin
			cpu_cnt <= cpu_cnt + 3'h1;
		end
	end

	// Default and unused strap code fall back to the pin
	always_comb begin
		case (src)
			emifc_pkg::SRC_CPU4: src_level = (cpu_cnt < (emifc_pkg::CPU4_COUNT >> 1));
			emifc_pkg::SRC_CPU6: src_level = (cpu_cnt < (emifc_pkg::CPU6_COUNT >> 1));
			default: src_level = ext_sync;
		endcase
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Full-rate clock follows the source level, no division
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_prev <= 1'b0;
			ext_if_clock_out_full <= 1'b0;
			tick <= 1'b0;
		end else begin
			src_prev <= src_level;
			ext_if_clock_out_full <= src_level;
			tick <= src_level & ~src_prev;
		end
	end

	// Divided clock: /1, /2 or /4 of the source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 2'h0;
			ext_if_clock_out_div <= 1'b0;
		end else begin
			if (src_level & ~src_prev) begin
				div_cnt <= div_cnt + 2'h1;
			end
			case (div_sel)
				emifc_pkg::DIV_BY2: ext_if_clock_out_div <= div_cnt[0];
				emifc_pkg::DIV_BY4: ext_if_clock_out_div <= div_cnt[1];
				default: ext_if_clock_out_div <= src_level;
			endcase
		end
	end

endmodule

/* src/emifc_top.sv */
// External memory control side: bus arbitration, clocks and shared strobes
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
module emifc_top (
	input wire logic pclk, // System clock, 10 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic acc_req, // Internal access request
	input wire logic [1:0] acc_type, // Memory type of the access
	input wire logic acc_write, // Access is a write
	output logic acc_ready, // Request is taken this cycle
	output logic acc_done, // Access finished, one cycle
	input wire logic host_hold_request, // Hold request pin from host
	output logic host_hold_acknowledge, // Hold acknowledge pin
	output logic bus_request_out, // Bus request pin
	input wire logic [1:0] clock_select_straps, // Strap pins, read after reset
	input wire logic ext_if_clock_in, // External interface clock pin
	output logic ext_if_clock_out_full, // Output clock at source rate
	output logic ext_if_clock_out_div, // Output clock at divided rate
	output logic shared_read_strobe_n, // Read, column or sync strobe pin
	output logic shared_read_strobe_oe_n, // Its output enable, low drives
	output logic shared_output_strobe_n, // Output enable or row strobe pin
	output logic shared_output_strobe_oe_n, // Its output enable, low drives
	output logic shared_write_strobe_n, // Write enable pin
	output logic shared_write_strobe_oe_n, // Its output enable, low drives
	output logic sdram_clock_enable // SDRAM clock enable or general output
);
	logic [6:0] ctrl;
	logic hreq_meta;
	logic hreq_s;
	logic [1:0] strap_meta;
	logic [1:0] strap_sync;
	logic strap_taken;
	logic [1:0] clk_src;
	logic tick;
	logic released;
	logic in_sref;
	logic [1:0] phase_cnt;
	logic [1:0] cur_type;
	logic cur_write;
	logic [2:0] next_strobes;
	logic sref_start;
	logic apb_access;
	logic addr_ok;
	emifc_pkg::emifc_arb_e arb;
	emifc_pkg::emifc_seq_e seq;

	// ----------------------------------------------------------------
	// Strobe decode
	// ----------------------------------------------------------------
	// Returns asserted strobes {read/cas/sync, output/ras, write}, active high
	function automatic logic [2:0] strobe_decode(input emifc_pkg::emifc_seq_e st,
			input logic [1:0] mtype, input logic wr, input logic res);
		logic [2:0] s;
		s = 3'h0;
		case (st)
			emifc_pkg::SEQ_SETUP: begin
				if (mtype == emifc_pkg::MEM_SDRAM) begin
					s = 3'b010; // Row activate
				end else if (mtype == emifc_pkg::MEM_SYNC && !res) begin
					s = {1'b1, 1'b0, wr}; // Address strobe
				end
			end
			emifc_pkg::SEQ_STROBE: begin
				case (mtype)
					emifc_pkg::MEM_ASYNC: s = wr ? 3'b001 : 3'b110;
					emifc_pkg::MEM_SDRAM: s = {1'b1, 1'b0, wr}; // Column strobe
					emifc_pkg::MEM_SYNC: s = wr ? 3'b001 : {res, 2'b10};
					default: s = 3'h0;
				endcase
			end
			emifc_pkg::SEQ_SREF: s = 3'b110; // Self-refresh command
			default: s = 3'h0;
		endcase
		return s;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers and strap capture
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hreq_meta <= 1'b0;
			hreq_s <= 1'b0;
		end else begin
			hreq_meta <= host_hold_request;
			hreq_s <= hreq_meta;
		end
	end

	// Strap flops run through reset, so the pins have settled by release
	always_ff @(posedge pclk) begin
		strap_meta <= clock_select_straps;
		strap_sync <= strap_meta;
	end

	// Straps are caught once, after the synchroniser has filled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_taken <= 1'b0;
			clk_src <= emifc_pkg::SRC_EXT;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			clk_src <= strap_sync;
		end
	end

	emifc_clkgen u_clkgen (
		.pclk(pclk),
		.presetn(presetn),
		.ext_if_clock_in(ext_if_clock_in),
		.src(clk_src),
		.div_sel(ctrl[emifc_pkg::CTRL_DIV_LSB +: 2]),
		.ext_if_clock_out_full(ext_if_clock_out_full),
		.ext_if_clock_out_div(ext_if_clock_out_div),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------------------------------
	assign apb_access = psel & penable;
	assign addr_ok = (paddr == emifc_pkg::ADDR_CTRL) || (paddr == emifc_pkg::ADDR_STATUS);
	assign pready = 1'b1;
	assign pslverr = apb_access & ~addr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= emifc_pkg::CTRL_RESET;
		end else if (apb_access && pwrite && paddr == emifc_pkg::ADDR_CTRL) begin
			ctrl <= pwdata[emifc_pkg::CTRL_WIDTH-1:0];
		end
	end

	// Read data is registered; status bits are sampled at the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			if (paddr == emifc_pkg::ADDR_CTRL) begin
				prdata[emifc_pkg::CTRL_WIDTH-1:0] <= ctrl;
			end else if (paddr == emifc_pkg::ADDR_STATUS) begin
				prdata[emifc_pkg::STAT_ACK_BIT] <= host_hold_acknowledge;
				prdata[emifc_pkg::STAT_SREF_BIT] <= in_sref;
				prdata[emifc_pkg::STAT_SRC_LSB +: 2] <= clk_src;
				prdata[emifc_pkg::STAT_BUSY_BIT] <= (seq != emifc_pkg::SEQ_IDLE);
				prdata[emifc_pkg::STAT_HREQ_BIT] <= hreq_s;
			end
		end
	end

	// ----------------------------------------------------------------
	// Hold arbitration
	// ----------------------------------------------------------------
	// The host keeps its request up for the whole tenure
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arb <= emifc_pkg::ARB_OWN;
		end else begin
			case (arb)
				emifc_pkg::ARB_OWN: if (hreq_s) arb <= emifc_pkg::ARB_DRAIN;
				emifc_pkg::ARB_DRAIN: begin
					if (!hreq_s) begin
						arb <= emifc_pkg::ARB_OWN;
					end else if (seq == emifc_pkg::SEQ_IDLE) begin
						arb <= emifc_pkg::ARB_FLOAT; // Access finished first
					end
				end
				emifc_pkg::ARB_FLOAT: arb <= emifc_pkg::ARB_HELD;
				emifc_pkg::ARB_HELD: if (!hreq_s) arb <= emifc_pkg::ARB_OWN;
				default: arb <= emifc_pkg::ARB_OWN;
			endcase
		end
	end

	// Outputs float one cycle before the acknowledge rises
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			released <= 1'b0;
			host_hold_acknowledge <= 1'b0;
			bus_request_out <= 1'b0;
		end else begin
			released <= hreq_s && (arb == emifc_pkg::ARB_FLOAT || arb == emifc_pkg::ARB_HELD ||
				(arb == emifc_pkg::ARB_DRAIN && seq == emifc_pkg::SEQ_IDLE));
			host_hold_acknowledge <= hreq_s && (arb == emifc_pkg::ARB_FLOAT ||
				arb == emifc_pkg::ARB_HELD);
			// Pending work or software asks for the bus back
			bus_request_out <= hreq_s && arb == emifc_pkg::ARB_HELD &&
				(acc_req || ctrl[emifc_pkg::CTRL_BREQ_BIT]);
		end
	end

	// ----------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------
	// New work only while the bus is ours and SDRAM is awake
	assign acc_ready = (seq == emifc_pkg::SEQ_IDLE) && (arb == emifc_pkg::ARB_OWN) &&
		!hreq_s && !in_sref && !ctrl[emifc_pkg::CTRL_SREF_BIT];
	assign sref_start = (seq == emifc_pkg::SEQ_IDLE) && (arb == emifc_pkg::ARB_OWN) &&
		!hreq_s && !in_sref && ctrl[emifc_pkg::CTRL_SREF_BIT] &&
		ctrl[emifc_pkg::CTRL_SDRAM_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq <= emifc_pkg::SEQ_IDLE;
			phase_cnt <= 2'h0;
			cur_type <= emifc_pkg::MEM_ASYNC;
			cur_write <= 1'b0;
		end else begin
			case (seq)
				emifc_pkg::SEQ_IDLE: begin
					if (acc_ready && acc_req) begin
						seq <= emifc_pkg::SEQ_SETUP;
						cur_type <= acc_type;
						cur_write <= acc_write;
					end else if (sref_start) begin
						seq <= emifc_pkg::SEQ_SREF;
					end
				end
				emifc_pkg::SEQ_SETUP: begin
					if (tick) begin
						seq <= emifc_pkg::SEQ_STROBE;
						phase_cnt <= emifc_pkg::STROBE_TICKS - 2'h1;
					end
				end
				emifc_pkg::SEQ_STROBE: begin
					if (tick) begin
						if (phase_cnt == 2'h0) begin
							seq <= emifc_pkg::SEQ_HOLD;
						end else begin
							phase_cnt <= phase_cnt - 2'h1;
						end
					end
				end
				emifc_pkg::SEQ_HOLD: if (tick) seq <= emifc_pkg::SEQ_IDLE;
				emifc_pkg::SEQ_SREF: if (tick) seq <= emifc_pkg::SEQ_IDLE;
				default: seq <= emifc_pkg::SEQ_IDLE;
			endcase
		end
	end

	// One-cycle completion pulse as the hold phase ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_done <= 1'b0;
		end else begin
			acc_done <= (seq == emifc_pkg::SEQ_HOLD) && tick;
		end
	end

	// ----------------------------------------------------------------
	// Self-refresh and clock enable
	// ----------------------------------------------------------------
	// Entered after the command tick, left when software drops the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_sref <= 1'b0;
		end else if (seq == emifc_pkg::SEQ_SREF && tick) begin
			in_sref <= 1'b1;
		end else if (!ctrl[emifc_pkg::CTRL_SREF_BIT] || !ctrl[emifc_pkg::CTRL_SDRAM_BIT]) begin
			in_sref <= 1'b0;
		end
	end

	// Without SDRAM the pin is a software output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdram_clock_enable <= 1'b1;
		end else if (!ctrl[emifc_pkg::CTRL_SDRAM_BIT]) begin
			sdram_clock_enable <= ctrl[emifc_pkg::CTRL_GPO_BIT];
		end else begin
			sdram_clock_enable <= !(in_sref || seq == emifc_pkg::SEQ_SREF);
		end
	end

	// ----------------------------------------------------------------
	// Shared strobe pins
	// ----------------------------------------------------------------
	assign next_strobes = strobe_decode(seq, cur_type, cur_write, ctrl[emifc_pkg::CTRL_RES_BIT]);

	// Registered so the pins never glitch between phases
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_read_strobe_n <= 1'b1;
			shared_output_strobe_n <= 1'b1;
			shared_write_strobe_n <= 1'b1;
		end else begin
			shared_read_strobe_n <= ~next_strobes[2];
			shared_output_strobe_n <= ~next_strobes[1];
			shared_write_strobe_n <= ~next_strobes[0];
		end
	end

	// Pins float while the host owns the bus
	assign shared_read_strobe_oe_n = released;
	assign shared_output_strobe_oe_n = released;
	assign shared_write_strobe_oe_n = released;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	float_on_ack_a: assert property (host_hold_acknowledge |-> released)
		else $error("acknowledge while bus outputs are driven");
	ack_after_float_a: assert property ($rose(host_hold_acknowledge) |->
		$past(released) && seq == emifc_pkg::SEQ_IDLE)
		else $error("acknowledge rose before outputs floated");
	ack_drop_a: assert property ($fell(hreq_s) |-> ##1 !host_hold_acknowledge)
		else $error("acknowledge held after request dropped");
	busreq_held_a: assert property (bus_request_out |-> host_hold_acknowledge)
		else $error("bus request while bus is ours");
	gpo_pin_a: assert property (!ctrl[emifc_pkg::CTRL_SDRAM_BIT] ##1
		!ctrl[emifc_pkg::CTRL_SDRAM_BIT] |-> sdram_clock_enable ==
		$past(ctrl[emifc_pkg::CTRL_GPO_BIT]))
		else $error("clock enable pin does not follow software value");
	sref_cke_a: assert property (in_sref && ctrl[emifc_pkg::CTRL_SDRAM_BIT] |=>
		!sdram_clock_enable)
		else $error("clock enable high during self-refresh");
	sync_ads_a: assert property (seq == emifc_pkg::SEQ_SETUP &&
		cur_type == emifc_pkg::MEM_SYNC && !ctrl[emifc_pkg::CTRL_RES_BIT] |=>
		!shared_read_strobe_n)
		else $error("address strobe missing in setup");
	sync_re_a: assert property (seq == emifc_pkg::SEQ_STROBE &&
		cur_type == emifc_pkg::MEM_SYNC && !cur_write |=>
		shared_read_strobe_n == !$past(ctrl[emifc_pkg::CTRL_RES_BIT]))
		else $error("read enable does not follow select");

	hold_cycle_c: cover property ($rose(host_hold_acknowledge) ##[1:50] !host_hold_acknowledge);
	sdram_access_c: cover property (seq == emifc_pkg::SEQ_STROBE &&
		cur_type == emifc_pkg::MEM_SDRAM ##[1:50] acc_done);
	sref_entry_c: cover property ($rose(in_sref));

endmodule

/* tb/emifc_host_model.sv */
// Host bus master and free-running external clock seen from the far side of the block
`timescale 1ns/1ns
module emifc_host_model (
	input wire logic pclk, // System clock
	input wire logic presetn, // Reset, active low
	input wire logic want, // Host needs the bus
	input wire logic host_hold_acknowledge, // Grant from the block
	output logic host_hold_request, // Hold request pin
	output logic ext_if_clock_in // Board clock, runs free
);
	// Board oscillator, 600 ns period; edges land on pclk falling edges, never on a rising one
	initial begin
		ext_if_clock_in = 1'b0;
		forever #300 ext_if_clock_in = ~ext_if_clock_in;
	end
	// Request stays up until granted, then for the whole tenure
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			host_hold_request <= 1'b0;
		else if (want)
			host_hold_request <= 1'b1;
		else if (host_hold_acknowledge)
			host_hold_request <= 1'b0;
	end
endmodule

/* tb/emifc_top_tb.sv */
// Self-checking bench for the external memory control block
`timescale 1ns/1ns
`define CHK(n, x, g) \
	n_checks++; \
	if ((g) !== (x)) begin \
		errors++; \
		$display("mismatch %s expected %0h seen %0h", n, x, g); \
	end
module emifc_top_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, want;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic acc_req, acc_write, acc_ready, acc_done, hreq, hack, breq, eclk, full, div;
	logic [1:0] acc_type, straps;
	logic rd, rd_oe, oe, oe_oe, wr, wr_oe, cke;
	logic [3:0] seen;
	logic [7:0] rows [9] = '{8'h0C, 8'h22, 8'h4D, 8'h6F, 8'h8D, 8'h9C, 8'hAB, 8'hB2, 8'hC0};
	int exp_div [4] = '{12, 6, 3, 12};
	int errors, n_checks, f, d;

	emifc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acc_req(acc_req), .acc_type(acc_type), .acc_write(acc_write),
		.acc_ready(acc_ready), .acc_done(acc_done), .host_hold_request(hreq),
		.host_hold_acknowledge(hack), .bus_request_out(breq), .clock_select_straps(straps),
		.ext_if_clock_in(eclk), .ext_if_clock_out_full(full), .ext_if_clock_out_div(div),
		.shared_read_strobe_n(rd), .shared_read_strobe_oe_n(rd_oe),
		.shared_output_strobe_n(oe), .shared_output_strobe_oe_n(oe_oe),
		.shared_write_strobe_n(wr), .shared_write_strobe_oe_n(wr_oe),
		.sdram_clock_enable(cke));
	emifc_host_model host (.pclk(pclk), .presetn(presetn), .want(want),
		.host_hold_acknowledge(hack), .host_hold_request(hreq), .ext_if_clock_in(eclk));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Setup then access; request held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rst(input logic [1:0] s);
		presetn <= 1'b0;
		straps <= s;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, emifc_pkg::ADDR_STATUS, 32'h0);
	endtask
	task wt(input logic v, input int which);
		int k;
		for (k = 0; k < 100 && (which ? cke : hack) !== v; k++)
			@(posedge pclk);
	endtask
	// Rising edges of both output clocks over 48 cycles
	task cnt;
		logic pf, pd;
		f = 0;
		d = 0;
		@(posedge pclk);
		#1 pf = full;
		pd = div;
		repeat (48) begin
			@(posedge pclk);
			#1 f += int'(full & ~pf);
			d += int'(div & ~pd);
			pf = full;
			pd = div;
		end
	endtask
	// One access; records which strobes went low and whether read fell while output stayed high
	task acc(input logic [1:0] t, input logic w);
		int i;
		seen = 4'h0;
		@(posedge pclk);
		acc_type <= t;
		acc_write <= w;
		acc_req <= 1'b1;
		@(posedge pclk);
		while (acc_ready !== 1'b1)
			@(posedge pclk);
		acc_req <= 1'b0;
		for (i = 0; i < 200 && acc_done !== 1'b1; i++) begin
			@(posedge pclk);
			#1 seen |= {~rd, ~oe, ~wr, ~rd & oe};
			`CHK("ack_mid_access", 1'b0, hack)
			`CHK("strobes_driven", 3'h0, {rd_oe, oe_oe, wr_oe})
		end
		`CHK("acc_done", 1'b1, acc_done)
	endtask

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		#3000000;
		errors++;
		end_sim;
	end
	initial begin
		{psel, penable, pwrite, acc_req, acc_write, want} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		acc_type = 2'h0;
		// Straps pick the source; code 2 is CPU/6, period 6 cycles
		rst(2'h2);
		`CHK("src", 2'h2, q[3:2])
		cnt;
		`CHK("cpu6_edges", 8, f)
		rst(2'h0);
		`CHK("src", 2'h0, q[3:2])
		cnt;
		`CHK("pin_edges", 8, f)
		rst(2'h3);
		`CHK("src", 2'h3, q[3:2])
		rst(2'h1);
		`CHK("src", 2'h1, q[3:2])
		$display("test reset and straps done");
		// CPU/4 source: full clock 12 edges, divided by ratio table
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, emifc_pkg::ADDR_CTRL, 32'(r));
			repeat (20) @(posedge pclk);
			cnt;
			`CHK("full_edges", 12, f)
			`CHK("div_edges", exp_div[r], d)
		end
		$display("test clocks done");
		// Strobe table: each row sets type, direction and select
		foreach (rows[r]) begin
			apb(1'b1, emifc_pkg::ADDR_CTRL, 32'h08 | (32'(rows[r][4]) << 2));
			acc(rows[r][7:6], rows[r][5]);
			`CHK("strobes_seen", rows[r][3:0], seen)
		end
		$display("test strobes done");
		// Hold raised in mid-access: grant only after the access ends
		fork
			acc(emifc_pkg::MEM_ASYNC, 1'b0);
			begin
				repeat (4) @(posedge pclk);
				want <= 1'b1;
			end
		join
		wt(1'b1, 0);
		`CHK("ack", 1'b1, hack)
		`CHK("floated", 3'h7, {rd_oe, oe_oe, wr_oe})
		`CHK("acc_ready_held", 1'b0, acc_ready)
		apb(1'b1, emifc_pkg::ADDR_CTRL, 32'h48);
		repeat (3) @(posedge pclk);
		`CHK("bus_request", 1'b1, breq)
		@(posedge pclk);
		want <= 1'b0;
		wt(1'b0, 0);
		repeat (2) @(posedge pclk);
		`CHK("redriven", 3'h0, {rd_oe, oe_oe, wr_oe})
		`CHK("bus_request", 1'b0, breq)
		$display("test hold done");
		// Self-refresh entry and exit, then general output use
		apb(1'b1, emifc_pkg::ADDR_CTRL, 32'h28);
		wt(1'b0, 1);
		// The entry tick can land up to one source period after the pin falls
		repeat (4) @(posedge pclk);
		apb(1'b0, emifc_pkg::ADDR_STATUS, 32'h0);
		`CHK("sref_cke", 1'b0, cke)
		`CHK("sref_stat", 1'b1, q[1])
		apb(1'b1, emifc_pkg::ADDR_CTRL, 32'h08);
		wt(1'b1, 1);
		`CHK("sref_exit", 1'b1, cke)
		apb(1'b1, emifc_pkg::ADDR_CTRL, 32'h00);
		wt(1'b0, 1);
		`CHK("gpo_low", 1'b0, cke)
		apb(1'b1, emifc_pkg::ADDR_CTRL, 32'h10);
		wt(1'b1, 1);
		`CHK("gpo_high", 1'b1, cke)
		apb(1'b0, 12'h008, 32'h0);
		`CHK("unmapped_err", 1'b1, e)
		`CHK("unmapped_data", 32'h0, q)
		$display("test refresh and register done");
		end_sim;
	end
endmodule
